// >>> shared/sesr_regs.vh
// Purpose: constants for the standard event status block
// Assumes: included by bare name from logic files
// Notes:   bit positions within the 16-bit event latch
`ifndef SESR_REGS_VH
`define SESR_REGS_VH
`define SESR_LATCH_WIDTH   16
`define SESR_EVENT_WIDTH   8
`define SESR_BIT_OPC       0
`define SESR_BIT_RQC       1
`define SESR_BIT_QYE       2
`define SESR_BIT_DDE       3
`define SESR_BIT_EXE       4
`define SESR_BIT_CME       5
`define SESR_BIT_URQ       6
`define SESR_BIT_PON       7
`define SESR_LATCH_RESET   16'h0080
`define SESR_EVENT_RESET   8'h80
`define SESR_ASCII_ZERO    8'h30
`define SESR_ASCII_LF      8'h0A
`endif

// >>> logic/sesr_dec_fmt.v
// Purpose: byte to three ASCII decimal digits
// Assumes: combinational, input 0..255
// Notes:   leading zeros are removed by the caller
`timescale 1ns/1ns
`default_nettype none
`include "sesr_regs.vh"
module sesr_dec_fmt (
  input  wire [7:0] value_i,
  output wire [7:0] hund_o,
  output wire [7:0] tens_o,
  output wire [7:0] ones_o,
  output wire [1:0] ndig_o
);
  wire [7:0] h;
  wire [7:0] rem1;
  wire [7:0] t;
  wire [7:0] o;
  assign h      = value_i / 8'h64;
  assign rem1   = value_i - h * 8'h64;
  assign t      = rem1 / 8'h0A;
  assign o      = rem1 - t * 8'h0A;
  assign hund_o = `SESR_ASCII_ZERO + h;
  assign tens_o = `SESR_ASCII_ZERO + t;
  assign ones_o = `SESR_ASCII_ZERO + o;
  assign ndig_o = (h != 8'h00) ? 2'h3 : ((t != 8'h00) ? 2'h2 : 2'h1);
endmodule // sesr_dec_fmt
`default_nettype wire

// >>> logic/sesr_event_latch.v
// Purpose: standard event status latch with query, clear and summary
// Assumes: event inputs are one-cycle pulses on sys_clk_i
// Notes:   query answer streams out as ASCII decimal then newline
`timescale 1ns/1ns
`default_nettype none
`include "sesr_regs.vh"
// Operation
// - Bits 8 to 15 of the latch always read as zero.
// - Bit 7 is set by power-up and stays until the latch is read or a clear command is given.
// - Bit 6 is never set.
// - Bit 5 is set on a command syntax, semantic or embedded trigger fault.
// - Bit 4 is set on an out-of-range parameter or inability to execute.
// - Bit 3 is set on an internal device-dependent failure.
// - Bit 2 is set on reading an empty queue or losing queued data.
// - Bit 1 is set when the device asks to become active controller.
// - Bit 0 is set only once an OPC request is armed and work is done.
// - A query returns the value as a decimal integer from 0 to 255.
// - A query clears every bit of the latch.
// - A clear command also clears every bit.
// - Summary bit goes high whenever an enabled event bit is set.
module sesr_event_latch (
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  input  wire        cmd_err_i,
  input  wire        exe_err_i,
  input  wire        dev_err_i,
  input  wire        qry_err_i,
  input  wire        req_ctl_i,
  input  wire        opc_cmd_i,
  input  wire        ops_idle_i,
  input  wire        cls_cmd_i,
  input  wire        query_i,
  input  wire [7:0]  enable_mask_i,
  input  wire        byte_ready_i,
  output reg  [15:0] event_status_latch_o,
  output reg         summary_o,
  output reg  [7:0]  resp_byte_o,
  output reg         resp_valid_o,
  output reg         busy_o
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SEND = 2'h1;

  reg  [7:0] lat;
  reg  [7:0] next_lat;
  reg        opc_armed;
  reg  [1:0] state;
  reg  [1:0] idx;
  reg  [7:0] snap;
  wire [7:0] hund;
  wire [7:0] tens;
  wire [7:0] ones;
  wire [1:0] ndig;
  reg  [7:0] sel_byte;
  wire       take_q;
  wire       opc_done;
  wire       byte_go;

  // Query accepted only while idle; a query during send is ignored
  assign take_q   = query_i && (state == ST_IDLE);
  assign opc_done = opc_armed && ops_idle_i;
  assign byte_go  = resp_valid_o && byte_ready_i;

  sesr_dec_fmt u_fmt (
    .value_i (snap),
    .hund_o  (hund),
    .tens_o  (tens),
    .ones_o  (ones),
    .ndig_o  (ndig)
  );

  always @* begin
    next_lat = lat;
    if (take_q || cls_cmd_i) begin
      next_lat = 8'h00;
    end
    // Sets applied after the clear so a same-cycle event is kept
    if (cmd_err_i) next_lat[`SESR_BIT_CME] = 1'b1;
    if (exe_err_i) next_lat[`SESR_BIT_EXE] = 1'b1;
    if (dev_err_i) next_lat[`SESR_BIT_DDE] = 1'b1;
    if (qry_err_i) next_lat[`SESR_BIT_QYE] = 1'b1;
    if (req_ctl_i) next_lat[`SESR_BIT_RQC] = 1'b1;
    if (opc_done) next_lat[`SESR_BIT_OPC] = 1'b1;
    next_lat[`SESR_BIT_URQ] = 1'b0;
  end

  always @* begin
    case (idx)
      2'h0:    sel_byte = (ndig == 2'h3) ? hund :
                          ((ndig == 2'h2) ? tens : ones);
      2'h1:    sel_byte = (ndig == 2'h3) ? tens :
                          ((ndig == 2'h2) ? ones : `SESR_ASCII_LF);
      2'h2:    sel_byte = (ndig == 2'h3) ? ones : `SESR_ASCII_LF;
      default: sel_byte = `SESR_ASCII_LF;
    endcase
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Power-on state reports the power cycle
      lat                  <= `SESR_EVENT_RESET;
      opc_armed            <= 1'b0;
      state                <= ST_IDLE;
      idx                  <= 2'h0;
      snap                 <= 8'h00;
      event_status_latch_o <= `SESR_LATCH_RESET;
      summary_o            <= 1'b0;
      resp_byte_o          <= 8'h00;
      resp_valid_o         <= 1'b0;
      busy_o               <= 1'b0;
    end else begin
      lat                  <= next_lat;
      event_status_latch_o <= {8'h00, next_lat};
      summary_o            <= |(next_lat & enable_mask_i);
      if (cls_cmd_i || opc_done) begin
        opc_armed <= 1'b0;
      end
      if (opc_cmd_i) begin
        opc_armed <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (take_q) begin
            snap   <= lat;
            idx    <= 2'h0;
            state  <= ST_SEND;
            busy_o <= 1'b1;
          end
        end
        ST_SEND: begin
          // Snapshot settles one cycle before first byte
          if (!resp_valid_o) begin
            resp_byte_o  <= sel_byte;
            resp_valid_o <= 1'b1;
          end else if (byte_go) begin
            if (resp_byte_o == `SESR_ASCII_LF) begin
              resp_valid_o <= 1'b0;
              state        <= ST_IDLE;
              busy_o       <= 1'b0;
            end else begin
              idx          <= idx + 2'h1;
              resp_valid_o <= 1'b0;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // sesr_event_latch
`default_nettype wire

// >>> sim/sesr_mon_monitor.sv
// Purpose: checks on the event latch ports
// Assumes: bound to sesr_event_latch
// Notes: bits 4..1 are checked as one group
`timescale 1ns/1ns
`default_nettype none
module sesr_mon (
  input wire logic        sys_clk_i, rst_b_i, cmd_err_i, exe_err_i,
  input wire logic        dev_err_i, qry_err_i, req_ctl_i, ops_idle_i,
  input wire logic        cls_cmd_i, query_i, busy_o,
  input wire logic        resp_valid_o, byte_ready_i,
  input wire logic [7:0]  resp_byte_o,
  input wire logic [15:0] event_status_latch_o
);
  wire [15:0] l  = event_status_latch_o;
  wire [3:0]  e4 = {exe_err_i, dev_err_i, qry_err_i, req_ctl_i};
  wire        ev = cmd_err_i | (|e4);
  wire        tk = query_i & !busy_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rsvd_zero: assert property (l[15:8] == 0 && !l[6])
    else $error("reserved bit set");
  a_cmd_set: assert property (cmd_err_i |=> l[5])
    else $error("command fault not latched");
  a_err_set: assert property (e4 != 0 |=> (l[4:1] & $past(e4)) == $past(e4))
    else $error("error event not latched");
  a_opc_gate: assert property ($rose(l[0]) |-> $past(ops_idle_i))
    else $error("completion bit set while busy");
  a_query_clr: assert property (tk && !ev |=> l[7:1] == 0)
    else $error("query did not clear");
  a_cls_clr: assert property (cls_cmd_i && !ev |=> l[7:1] == 0)
    else $error("clear command did not clear");
  a_bit_sticky: assert property (l[5] && !tk && !cls_cmd_i |=> l[5])
    else $error("event bit lost");
  a_busy_seq: assert property (tk |=> busy_o ##1 busy_o)
    else $error("query not started");
  a_byte_hold: assert property (resp_valid_o && !byte_ready_i |=> resp_valid_o && $stable(resp_byte_o))
    else $error("response byte dropped before accept");
endmodule // sesr_mon
bind sesr_event_latch sesr_mon sesr_mon_inst (.*);
`default_nettype wire

// >>> sim/sesr_host.sv
// Purpose: output queue reader on the far side
// Assumes: bytes accepted on valid and ready
// Notes: slow mode takes a byte every other cycle
`timescale 1ns/1ns
`default_nettype none
module sesr_host (
  input  wire logic        clk_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        valid_i,
  input  wire logic        slow_i,
  output logic             ready_o,
  output logic [31:0]      rx_o
);
  logic t;
  initial t = 1'b0;
  initial rx_o = 32'h0;
  always @(posedge clk_i) begin
    t <= ~t;
    if (valid_i && ready_o) rx_o <= {rx_o[23:0], byte_i};
  end
  assign ready_o = !slow_i | t;
endmodule // sesr_host
`default_nettype wire

// >>> sim/sesr_event_latch_tb.sv
// Purpose: directed test of the event latch
// Assumes: host model reads the answer
// Notes: answers compared as packed ASCII
`timescale 1ns/1ns
`default_nettype none
module sesr_event_latch_tb;
  logic clk = 0, rst_b = 0, opc = 0, idle = 0, cls = 0, q = 0, sl = 0;
  logic [4:0] ev = 0;
  logic [7:0] mask = 0, rb;
  logic [15:0] latch;
  logic [31:0] rx;
  logic summary, rv, busy, rdy;
  int mismatches = 0, comparisons = 0;
  initial forever #2 clk = ~clk;
  sesr_event_latch sesr_event_latch_inst (.sys_clk_i(clk), .rst_b_i(rst_b),
    .cmd_err_i(ev[4]), .exe_err_i(ev[3]), .dev_err_i(ev[2]),
    .qry_err_i(ev[1]), .req_ctl_i(ev[0]), .opc_cmd_i(opc),
    .ops_idle_i(idle), .cls_cmd_i(cls), .query_i(q), .enable_mask_i(mask),
    .byte_ready_i(rdy), .event_status_latch_o(latch), .summary_o(summary),
    .resp_byte_o(rb), .resp_valid_o(rv), .busy_o(busy));
  sesr_host sesr_host_inst (.clk_i(clk), .byte_i(rb), .valid_i(rv),
    .slow_i(sl), .ready_o(rdy), .rx_o(rx));
  task complete_run;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pulse(input logic [4:0] v);
    @(posedge clk) ev <= v;
    @(posedge clk) ev <= 5'h00;
  endtask
  task qry(input logic s, input logic [31:0] e, input logic [31:0] m);
    int i;
    @(posedge clk) begin q <= 1'b1; sl <= s; end
    @(posedge clk) q <= 1'b0;
    tick(1);
    for (i = 0; i < 99 && busy !== 1'b0; i++) tick(1);
    if (i == 99) begin mismatches++; complete_run(); end
    chk("answer", e, rx & m);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    qry(0, 32'h3132380A, 32'hFFFFFFFF);
    qry(1, 32'h300A, 32'hFFFF);
    pulse(5'h10);
    mask <= 8'h20;
    tick(3);
    chk("latch", 32'h20, 32'(latch));
    chk("summary", 1, 32'(summary));
    qry(1, 32'h33320A, 32'hFFFFFF);
    pulse(5'h0F);
    qry(0, 32'h33300A, 32'hFFFFFF);
    @(posedge clk) opc <= 1'b1;
    @(posedge clk) opc <= 1'b0;
    tick(4);
    chk("opc idle", 0, 32'(latch));
    @(posedge clk) idle <= 1'b1;
    tick(3);
    chk("opc done", 1, 32'(latch));
    @(posedge clk) cls <= 1'b1;
    @(posedge clk) cls <= 1'b0;
    tick(0);
    chk("cleared", 0, 32'(latch));
    complete_run();
  end
endmodule // sesr_event_latch_tb
`default_nettype wire
